// >>> xpt_consts.svh
`ifndef XPT_CONSTS_SVH
`define XPT_CONSTS_SVH
`define ADDR_KEY    12'h000
`define ADDR_STAT   12'h004
`define ADDR_STEP   12'h008
`define ADDR_ENTRY  12'h00C
`define ADDR_CFG    12'h010
`define ADDR_ROWSEL 12'h014
`define ROWS        8
`define SLOT_COLS   12
`define SLOTS       6
`define UNIT_COLS   72
`define HALF_COL    10'h024
`define MAX_UNITS   3'h5
`define MAX_LOC     7'h64
`define CFG_RST     32'h0000_0001
`define MSG_TIME_MS 2
`define CLK_KHZ     40000
`define MSG_CYCLES  (`MSG_TIME_MS * `CLK_KHZ)
`endif

// >>> xpt_pkg.sv
`include "xpt_consts.svh"
package xpt_pkg;
   typedef logic [`ROWS-1:0][`SLOTS*`SLOT_COLS-1:0] disp_t;
   typedef enum logic [4:0] {
      K_D0 = 5'h00, K_ROW_A = 5'h0A, K_ROW_H = 5'h11, K_ENTER = 5'h12,
      K_CANCEL = 5'h13, K_MEM = 5'h14, K_RLY = 5'h15, K_UP = 5'h16,
      K_DN = 5'h17, K_OPEN = 5'h18, K_CLOSE = 5'h19, K_CLEAR = 5'h1A,
      K_LOCAL = 5'h1B, K_AUTO = 5'h1C, K_MB = 5'h1D, K_BM = 5'h1E
   } key_e;
   typedef enum logic [2:0] {
      SRC_MEM = 3'b001, SRC_RLY = 3'b010, SRC_EDIT = 3'b100
   } src_e;
   typedef enum logic [1:0] {MSG_NONE, MSG_RANGE, MSG_PEN} msg_e;
   typedef enum logic [1:0] {PEN_MISS, PEN_XPT, PEN_MB, PEN_BM} pen_k_e;
   typedef enum logic [1:0] {RQ_SET, RQ_CLR_ALL, RQ_SETUP} rq_e;
   typedef struct packed {
      pen_k_e     kind;
      logic [2:0] row;
      logic [6:0] col;
      logic       half;
   } pen_s;
   typedef struct packed {
      logic       ren;
      logic       llo;
      logic       lag;
      logic       tag;
      logic       unl;
      logic [4:0] addr;
   } bus_s;
   typedef struct packed {
      rq_e        op;
      logic [2:0] row;
      logic [6:0] col;
      logic       val;
      logic [6:0] loc;
   } relay_s;
   typedef struct packed {
      logic       row_v;
      logic [2:0] row;
      logic       num_v;
      logic [9:0] num;
   } entry_s;
   typedef struct packed {
      logic [21:0] rsv;
      logic        auto_on;
      msg_e        msg;
      logic        lockout;
      logic        listen;
      logic        talk;
      logic        remote;
      src_e        src;
   } stat_s;
   typedef struct packed {
      logic [23:0] rsv;
      logic [4:0]  own_addr;
      logic [2:0]  units;
   } cfg_s;
endpackage : xpt_pkg

// >>> xpt_step.sv
`include "xpt_consts.svh"
module xpt_step
   import xpt_pkg::*;
#(
   parameter logic [6:0] MAX       = `MAX_LOC,
   parameter bit         SKIP_ZERO = 1'b1
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       load,
   input  wire logic [6:0] load_val,
   input  wire logic       up,
   input  wire logic       down,
   output logic [6:0]      nxt,
   output logic [6:0]      value
);
   localparam logic [6:0] LOW = SKIP_ZERO ? 7'h01 : 7'h00;
   function automatic logic [6:0] step(input logic [6:0] v, input logic u);
      if (u) step = (v >= MAX) ? LOW : v + 7'h01;
      else step = (v <= LOW) ? MAX : v - 7'h01;
   endfunction : step
   always_comb begin
      if (load) nxt = load_val;
      else if (up) nxt = step(value, 1'b1);
      else if (down) nxt = step(value, 1'b0);
      else nxt = value;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) value <= 7'h01;
      else value <= nxt;
   end
   chk_wrap_top: assert property (@(posedge pclk) disable iff (!presetn)
      (up && !load && value == MAX) |=> value == LOW)
      else $error("step did not wrap at top");
endmodule : xpt_step

// >>> xpt_bus_if.sv
module xpt_bus_if
   import xpt_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  bus_s            bus,
   input  wire logic [4:0] own_addr,
   input  wire logic       local_key,
   output logic            talk,
   output logic            listen,
   output logic            remote,
   output logic            lockout
);
   logic mine;
   assign mine = bus.addr == own_addr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         talk   <= 1'b0;
         listen <= 1'b0;
      end else begin
         if (bus.tag) talk <= mine;
         if (bus.lag && mine) listen <= 1'b1;
         else if (bus.unl) listen <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) remote <= 1'b0;
      else if (!bus.ren) remote <= 1'b0;
      else if (bus.lag && mine) remote <= 1'b1;
      else if (local_key && !lockout) remote <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lockout <= 1'b0;
      else if (!bus.ren) lockout <= 1'b0;
      else if (bus.llo) lockout <= 1'b1;
   end
   chk_listen_own: assert property (@(posedge pclk) disable iff (!presetn)
      (bus.lag && bus.addr == own_addr) |=> listen)
      else $error("listen lamp not lit for own address");
   chk_remote_set: assert property (@(posedge pclk) disable iff (!presetn)
      (bus.lag && mine && bus.ren) |=> remote)
      else $error("remote not entered");
   chk_llo_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (remote && lockout && bus.ren && local_key) |=> remote)
      else $error("local key left remote under lockout");
endmodule : xpt_bus_if

// >>> xpt_panel.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`include "xpt_consts.svh"
module xpt_panel
   import xpt_pkg::*;
#(
   parameter int unsigned MSG_CYCLES = `MSG_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pen_valid,
   input  pen_s             pen,
   input  wire logic        trig,
   input  bus_s             bus,
   input  disp_t            mem_data,
   input  disp_t            relay_data,
   output disp_t            disp,
   output logic [6:0]       mem_loc,
   output relay_s           relay_req,
   output logic             relay_valid,
   output src_e             src,
   output msg_e             msg,
   output logic [15:0]      mb_sel,
   output logic [15:0]      bm_sel,
   output logic             talk,
   output logic             listen,
   output logic             remote
);
   ////////////////////////////////////////////////////////////////////
   cfg_s        cfg_q;
   entry_s      ent_q;
   logic        auto_q, pen_pend_q, trig_pend_q, lockout;
   pen_s        pen_q;
   logic [31:0] msg_cnt_q;
   logic [6:0]  mem_nxt, rly_nxt, rly_step;
   logic        acc, wr, go, sv_pen, sv_trig, edited, scr_up, scr_dn;
   logic        loc_ok, rloc_ok, xpt_ok, lo_half;
   key_e        kc;
   logic [6:0]  ecol;

   function automatic logic [9:0] col_max(input logic [2:0] u);
      logic [2:0] n;
      n = (u == 3'h0) ? 3'h1 : ((u > `MAX_UNITS) ? `MAX_UNITS : u);
      col_max = 10'(`UNIT_COLS) * 10'(n);
   endfunction : col_max

   function automatic logic is_key(input logic g, input key_e a, b);
      is_key = g && a == b;
   endfunction : is_key

   ////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, read data latched in setup phase
   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign pready  = 1'b1;
   assign pslverr = acc && !(paddr == `ADDR_KEY || paddr == `ADDR_STAT ||
                    paddr == `ADDR_STEP || paddr == `ADDR_ENTRY ||
                    paddr == `ADDR_CFG || paddr == `ADDR_ROWSEL);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         if (paddr == `ADDR_STAT)
            prdata <= stat_s'{22'h0, auto_q, msg, lockout, listen, talk,
                              remote, src};
         else if (paddr == `ADDR_STEP)
            prdata <= {9'h0, rly_step, 9'h0, mem_loc};
         else if (paddr == `ADDR_ENTRY) prdata <= {17'h0, ent_q};
         else if (paddr == `ADDR_CFG) prdata <= cfg_q;
         else if (paddr == `ADDR_ROWSEL) prdata <= {bm_sel, mb_sel};
         else prdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cfg_q <= `CFG_RST;
      else if (wr && paddr == `ADDR_CFG)
         cfg_q <= {24'h0, pwdata[7:0]};
   end

   ////////////////////////////////////////////////////////////////////
   // Event arbitration: key write first, then pen, then trigger
   assign kc      = key_e'(pwdata[4:0]);
   assign go      = wr && paddr == `ADDR_KEY &&
                    (!remote || kc == K_LOCAL);
   assign sv_pen  = pen_pend_q && !go;
   assign sv_trig = trig_pend_q && !go && !pen_pend_q;

   // A new arrival wins over the clear of the one being served
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pen_pend_q  <= 1'b0;
         trig_pend_q <= 1'b0;
         pen_q       <= '0;
      end else begin
         pen_pend_q  <= (pen_valid && !remote) || (pen_pend_q && !sv_pen);
         trig_pend_q <= trig || (trig_pend_q && !sv_trig);
         if (pen_valid && !remote && (!pen_pend_q || sv_pen))
            pen_q <= pen;
      end
   end

   xpt_bus_if u_bus (
      .pclk      (pclk),
      .presetn   (presetn),
      .bus       (bus),
      .own_addr  (cfg_q.own_addr),
      .local_key (is_key(go, kc, K_LOCAL)),
      .talk      (talk),
      .listen    (listen),
      .remote    (remote),
      .lockout   (lockout)
   );

   ////////////////////////////////////////////////////////////////////
   // Keyed entry
   assign edited  = src == SRC_EDIT;
   assign loc_ok  = ent_q.num_v && ent_q.num != 10'h0 &&
                    ent_q.num <= 10'(`MAX_LOC);
   assign rloc_ok = ent_q.num_v && ent_q.num <= 10'(`MAX_LOC);
   assign xpt_ok  = ent_q.row_v && ent_q.num_v && ent_q.num != 10'h0 &&
                    ent_q.num <= col_max(cfg_q.units);
   assign lo_half = !(ent_q.num_v && ent_q.num > `HALF_COL);
   assign ecol    = 7'(ent_q.num - 10'h1);
   assign scr_up  = is_key(go, kc, K_UP) && !edited;
   assign scr_dn  = is_key(go, kc, K_DN) && !edited;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ent_q <= '0;
      else if (go) begin
         if (kc < K_ROW_A) begin
            ent_q.num_v <= 1'b1;
            if (ent_q.num < 10'h064)
               ent_q.num <= 10'(ent_q.num * 10'hA + 10'(kc));
         end else if (kc <= K_ROW_H) begin
            ent_q.row_v <= 1'b1;
            ent_q.row   <= 3'(kc - K_ROW_A);
         end else if (kc != K_UP && kc != K_DN && kc != K_AUTO &&
                      kc != K_LOCAL)
            ent_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Step indices
   logic mem_ld, rly_ld, mem_scr, rly_scr;
   assign mem_ld  = loc_ok && (is_key(go, kc, K_MEM) ||
                    (is_key(go, kc, K_ENTER) && src == SRC_MEM));
   assign rly_ld  = rloc_ok && (is_key(go, kc, K_RLY) ||
                    (is_key(go, kc, K_ENTER) && src == SRC_RLY));
   assign mem_scr = src == SRC_MEM;
   assign rly_scr = src == SRC_RLY;

   xpt_step #(.MAX(`MAX_LOC), .SKIP_ZERO(1'b1)) u_mem_step (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (mem_ld),
      .load_val (ent_q.num[6:0]),
      .up       (scr_up && mem_scr),
      .down     (scr_dn && mem_scr),
      .nxt      (mem_nxt),
      .value    (mem_loc)
   );

   xpt_step #(.MAX(`MAX_LOC), .SKIP_ZERO(1'b0)) u_rly_step (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (rly_ld),
      .load_val (ent_q.num[6:0]),
      .up       ((scr_up && rly_scr) || sv_trig),
      .down     (scr_dn && rly_scr),
      .nxt      (rly_nxt),
      .value    (rly_step)
   );

   ////////////////////////////////////////////////////////////////////
   // Display source
   logic ed_xpt, ed_pen, ed_clr, bad;
   assign ed_xpt = xpt_ok && (is_key(go, kc, K_OPEN) ||
                   is_key(go, kc, K_CLOSE));
   assign ed_clr = is_key(go, kc, K_CLEAR);
   assign ed_pen = sv_pen && pen_q.kind == PEN_XPT;
   assign bad    = ((is_key(go, kc, K_MEM) ||
                   (is_key(go, kc, K_ENTER) && src == SRC_MEM)) &&
                   ent_q.num_v && !loc_ok) ||
                   ((is_key(go, kc, K_RLY) ||
                   (is_key(go, kc, K_ENTER) && src == SRC_RLY)) &&
                   ent_q.num_v && !rloc_ok) ||
                   ((is_key(go, kc, K_OPEN) || is_key(go, kc, K_CLOSE)) &&
                   !xpt_ok);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) src <= SRC_RLY;
      else if (ed_xpt || ed_pen || ed_clr) src <= SRC_EDIT;
      else if (is_key(go, kc, K_MEM) && !bad) src <= SRC_MEM;
      else if (is_key(go, kc, K_RLY) && !bad) src <= SRC_RLY;
   end

   // Tracking a live source refreshes only while its lamp is lit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) disp <= '0;
      else if (ed_clr) disp <= '0;
      else if (ed_xpt && ent_q.num <= 10'(`UNIT_COLS))
         disp[ent_q.row][ecol] <= kc == K_CLOSE;
      else if (ed_pen)
         disp[pen_q.row][pen_q.col] <= !disp[pen_q.row][pen_q.col];
      else begin
         case (src)
            SRC_MEM: disp <= mem_data;
            SRC_RLY: disp <= relay_data;
            SRC_EDIT: disp <= disp;
            default: disp <= disp;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Relay requests; sent for any accepted column, but only columns of this unit change the display
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) auto_q <= 1'b0;
      else if (is_key(go, kc, K_AUTO)) auto_q <= !auto_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_valid <= 1'b0;
         relay_req   <= '0;
      end else begin
         relay_valid <= 1'b0;
         if (ed_clr && auto_q) begin
            relay_valid  <= 1'b1;
            relay_req.op <= RQ_CLR_ALL;
         end else if ((ed_xpt || ed_pen) && auto_q) begin
            relay_valid   <= 1'b1;
            relay_req.op  <= RQ_SET;
            relay_req.row <= ed_pen ? pen_q.row : ent_q.row;
            relay_req.col <= ed_pen ? pen_q.col : ecol;
            relay_req.val <= ed_pen ? !disp[pen_q.row][pen_q.col]
                                    : kc == K_CLOSE;
         end else if ((rly_ld || sv_trig || (rly_scr &&
                      (scr_up || scr_dn))) && rly_nxt != 7'h00) begin
            relay_valid   <= 1'b1;
            relay_req.op  <= RQ_SETUP;
            relay_req.loc <= rly_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Row selection, lower half at bits 7:0, upper at 15:8
   logic        rs_key, rs_mb, rs_pen;
   logic [3:0]  rs_idx;
   assign rs_pen = sv_pen && (pen_q.kind == PEN_MB || pen_q.kind == PEN_BM);
   assign rs_key = go && (kc == K_MB || kc == K_BM) && ent_q.row_v;
   assign rs_mb  = rs_pen ? pen_q.kind == PEN_MB : kc == K_MB;
   assign rs_idx = rs_pen ? {pen_q.half, pen_q.row}
                          : {!lo_half, ent_q.row};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mb_sel <= 16'h0000;
         bm_sel <= 16'h0000;
      end else if ((rs_key || rs_pen) && rs_mb) begin
         mb_sel[rs_idx] <= !mb_sel[rs_idx];
         if (!mb_sel[rs_idx]) bm_sel[rs_idx] <= 1'b0;
      end else if (rs_key || rs_pen) begin
         bm_sel[rs_idx] <= !bm_sel[rs_idx];
         if (!bm_sel[rs_idx]) mb_sel[rs_idx] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Brief messages; the shown display is never disturbed by them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg       <= MSG_NONE;
         msg_cnt_q <= 32'h0000_0000;
      end else if (bad) begin
         msg       <= MSG_RANGE;
         msg_cnt_q <= 32'(MSG_CYCLES);
      end else if (sv_pen && pen_q.kind == PEN_MISS) begin
         msg       <= MSG_PEN;
         msg_cnt_q <= 32'(MSG_CYCLES);
      end else if (msg_cnt_q > 32'h0000_0001)
         msg_cnt_q <= msg_cnt_q - 32'h0000_0001;
      else begin
         msg       <= MSG_NONE;
         msg_cnt_q <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_clear_key;
      wr && paddr == `ADDR_KEY && !remote && kc == K_CLEAR;
   endsequence
   sequence s_all_off;
      disp == '0 && src == SRC_EDIT;
   endsequence

   chk_src_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(src))
      else $error("source lamps not one-hot");
   chk_remote_keys: assert property (@(posedge pclk) disable iff (!presetn)
      (remote && wr && paddr == `ADDR_KEY && kc != K_LOCAL)
      |=> $stable(src) && $stable(ent_q))
      else $error("key acted while in remote");
   chk_mem_nonzero: assert property (@(posedge pclk) disable iff (!presetn)
      mem_loc != 7'h00 && mem_loc <= `MAX_LOC)
      else $error("stored-setup index out of range");
   chk_rsel_excl: assert property (@(posedge pclk) disable iff (!presetn)
      (mb_sel & bm_sel) == 16'h0000)
      else $error("row selected for both modes");
   chk_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
      s_clear_key |=> s_all_off ##0 (relay_valid == auto_q))
      else $error("clear did not blank display");
   chk_edit_lamp: assert property (@(posedge pclk) disable iff (!presetn)
      (ed_xpt || ed_pen) |=> src == SRC_EDIT)
      else $error("edit did not light edited lamp");
   chk_scroll_edit: assert property (@(posedge pclk) disable iff (!presetn)
      (edited && go && (kc == K_UP || kc == K_DN))
      |=> $stable(mem_loc) && $stable(rly_step))
      else $error("scroll acted while edited");
   chk_trig_next: assert property (@(posedge pclk) disable iff (!presetn)
      (sv_trig && rly_step != `MAX_LOC)
      |=> rly_step == $past(rly_step) + 7'h01 && relay_valid)
      else $error("trigger did not send next setup");
   chk_bad_col: assert property (@(posedge pclk) disable iff (!presetn)
      (go && kc == K_CLOSE && ent_q.num_v &&
      ent_q.num > col_max(cfg_q.units)) |=> msg == MSG_RANGE)
      else $error("oversized column accepted");
   chk_rly_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rly_ld && ent_q.num == 10'h000) |=> !relay_valid)
      else $error("location zero sent to relays");
   chk_rly_track: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SRC_RLY && !ed_xpt && !ed_pen && !ed_clr)
      |=> disp == $past(relay_data))
      else $error("display not tracking relays");
endmodule : xpt_panel

// >>> setup_relay_model.sv
module setup_relay_model
   import xpt_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [6:0] mem_loc,
   input  relay_s          relay_req,
   input  wire logic       relay_valid,
   output disp_t           mem_data,
   output disp_t           relay_data
);
   ////////////////////////////////////////////////////////////////////////
   // One marked bit per location; locations 72 apart give the same pattern
   function automatic disp_t pat(input logic [6:0] loc);
      disp_t p;
      p = '0;
      p[loc[2:0]][loc % 72] = 1'b1;
      return p;
   endfunction : pat

   assign mem_data = pat(mem_loc);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_data <= '0;
      end else if (relay_valid) begin
         case (relay_req.op)
            RQ_SET:
               relay_data[relay_req.row][relay_req.col] <= relay_req.val;
            RQ_CLR_ALL: relay_data <= '0;
            RQ_SETUP:   relay_data <= pat(relay_req.loc);
            default:    relay_data <= relay_data;
         endcase
      end
   end
endmodule : setup_relay_model

// >>> crosspoint_display_controller_tb.sv
`include "xpt_consts.svh"
module crosspoint_display_controller_tb
   import xpt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] NK = 5'h1F;
   logic        pclk, presetn, psel, penable, pwrite, pen_valid, trig;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err_seen, relay_valid, talk, listen, remote;
   pen_s        pen;
   bus_s        bus;
   disp_t       mem_w, rly_w, disp, e;
   logic [6:0]  mem_loc;
   relay_s      relay_req;
   src_e        src;
   msg_e        msg;
   logic [15:0] mb_sel, bm_sel;
   int          err_count = 0;
   int          check_count = 0;

   xpt_panel #(.MSG_CYCLES(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pen_valid(pen_valid), .pen(pen),
      .trig(trig), .bus(bus), .mem_data(mem_w), .relay_data(rly_w),
      .disp(disp), .mem_loc(mem_loc), .relay_req(relay_req),
      .relay_valid(relay_valid), .src(src), .msg(msg), .mb_sel(mb_sel),
      .bm_sel(bm_sel), .talk(talk), .listen(listen), .remote(remote));

   setup_relay_model far (
      .pclk(pclk), .presetn(presetn), .mem_loc(mem_loc),
      .relay_req(relay_req), .relay_valid(relay_valid),
      .mem_data(mem_w), .relay_data(rly_w));

   always #12.5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task chk(input logic [575:0] seen,
            input logic [575:0] exp,
            input string        what);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s", $time, what);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         end_of_test();
      end
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Up to three key codes per call, NK marks an empty slot
   task keys(input logic [14:0] s);
      for (int i = 2; i >= 0; i--)
         if (s[i*5+:5] != NK) apb(1'b1, `ADDR_KEY, {27'h0, s[i*5+:5]});
      repeat (3) @(posedge pclk);
   endtask : keys

   task bus_ev(input bus_s b);
      @(posedge pclk);
      bus <= b;
      @(posedge pclk);
      bus <= {b.ren, 9'h000};
      repeat (2) @(posedge pclk);
   endtask : bus_ev

   task pulse(input logic t, input pen_s p);
      @(posedge pclk);
      trig <= t;
      pen_valid <= !t;
      pen <= p;
      @(posedge pclk);
      trig <= 1'b0;
      pen_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_of_test();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pen_valid = 1'b0;
      trig = 1'b0;
      paddr = '0;
      pwdata = '0;
      pen = '0;
      bus = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_STAT, 32'h0);
      chk(rd[2:0], SRC_RLY, "source after reset");
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk(rd, 32'h0001_0001, "steps after reset");
      apb(1'b0, 12'h018, 32'h0);
      chk(err_seen, 1'b1, "unmapped read");
      $display("test reset done");
      apb(1'b1, `ADDR_CFG, 32'h0000_0029);
      bus_ev({1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h05});
      chk({listen, remote}, 2'b11, "listen and remote");
      bus_ev({1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h05});
      chk(talk, 1'b1, "talk lamp");
      keys({NK, NK, K_MEM});
      chk(src, SRC_RLY, "key ignored in remote");
      bus_ev({1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h05});
      keys({NK, NK, K_LOCAL});
      chk(remote, 1'b1, "local under lockout");
      bus_ev({1'b0, 9'h000});
      bus_ev({1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h05});
      keys({NK, NK, K_LOCAL});
      chk(remote, 1'b0, "local key");
      bus_ev({1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h05});
      chk(listen, 1'b0, "unlisten");
      $display("test bus done");
      keys({NK, K_ROW_A, 5'h03});
      apb(1'b0, `ADDR_ENTRY, 32'h0);
      chk(rd, 32'h0000_4403, "entry");
      keys({NK, NK, K_CANCEL});
      apb(1'b0, `ADDR_ENTRY, 32'h0);
      chk(rd, 32'h0000_0000, "cancel");
      keys({K_ROW_A, 5'h03, K_CLOSE});
      chk({disp[0][2], src}, {1'b1, SRC_EDIT}, "close edits");
      keys({NK, NK, K_UP});
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk(rd, 32'h0001_0001, "scroll while edited");
      keys({K_ROW_A, 5'h07, 5'h03});
      keys({NK, NK, K_CLOSE});
      chk(msg, MSG_RANGE, "column 73");
      keys({NK, NK, K_CLEAR});
      chk(disp, '0, "clear");
      $display("test edit done");
      keys({NK, NK, K_MEM});
      chk({src, disp === far.pat(7'h01)}, {SRC_MEM, 1'b1}, "memory key");
      keys({K_UP, K_DN, K_DN});
      chk(mem_loc, 7'h64, "memory skips zero down");
      keys({NK, NK, K_UP});
      chk(mem_loc, 7'h01, "memory skips zero up");
      keys({5'h01, 5'h00, 5'h01});
      keys({NK, NK, K_MEM});
      chk({msg, mem_loc}, {MSG_RANGE, 7'h01}, "location 101");
      keys({5'h05, K_MEM, NK});
      keys({5'h07, K_ENTER, NK});
      chk(mem_loc, 7'h07, "enter location");
      $display("test memory done");
      keys({5'h01, 5'h00, 5'h00});
      keys({NK, NK, K_RLY});
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk({rd[22:16], disp === far.pat(7'h64)}, {7'h64, 1'b1}, "send 100");
      keys({NK, NK, K_UP});
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk({rd[22:16], disp === far.pat(7'h64)}, {7'h00, 1'b1}, "wrap to 0");
      keys({NK, K_UP, K_DN});
      keys({NK, NK, K_DN});
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk({rd[22:16], disp === far.pat(7'h64)}, {7'h64, 1'b1}, "wrap down");
      pulse(1'b1, '0);
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk({rd[22:16], disp === far.pat(7'h64)}, {7'h00, 1'b1}, "trigger to 0");
      pulse(1'b1, '0);
      chk(disp, far.pat(7'h01), "trigger sends 1");
      keys({NK, 5'h00, K_RLY});
      apb(1'b0, `ADDR_STEP, 32'h0);
      chk({rd[22:16], disp === far.pat(7'h01)}, {7'h00, 1'b1}, "location 0");
      $display("test relays done");
      e = far.pat(7'h01);
      e[1][4] = 1'b1;
      pulse(1'b0, {PEN_XPT, 3'h1, 7'h04, 1'b0});
      chk({disp === e, src}, {1'b1, SRC_EDIT}, "pen toggle");
      pulse(1'b0, {PEN_MISS, 11'h000});
      chk(msg, MSG_PEN, "pen miss");
      pulse(1'b0, {PEN_MB, 3'h2, 7'h00, 1'b0});
      pulse(1'b0, {PEN_BM, 3'h2, 7'h00, 1'b0});
      pulse(1'b0, {PEN_BM, 3'h3, 7'h00, 1'b1});
      chk({mb_sel[2], bm_sel[2], bm_sel[11]}, 3'b011, "row select");
      keys({NK, K_ROW_A, K_MB});
      keys({NK, K_ROW_A, K_BM});
      chk({mb_sel[0], bm_sel[0]}, 2'b01, "row keys");
      $display("test pen done");
      keys({K_AUTO, K_ROW_A, 5'h05});
      keys({NK, NK, K_CLOSE});
      chk(rly_w[0][4], 1'b1, "auto close");
      keys({NK, NK, K_CLEAR});
      chk(rly_w, '0, "auto clear relays");
      chk(disp, '0, "auto clear display");
      $display("test auto done");
      end_of_test();
   end
endmodule : crosspoint_display_controller_tb
